// file: hw/ufl_top.sv
// Line format and fifo control of one UART channel, with its serial engine.
// Assumes the host port is synchronous to clk_sys; rx_pin is asynchronous.
`timescale 1ns/1ps

// Synchronous fifo; flush clears pointers and count only
module ufl_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic                       clk_sys,
	input  wire logic                       sys_rst,
	input  wire logic                       flush,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [W-1:0]               in_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [W-1:0]                    out_data,
	output logic [$clog2(DEPTH):0]          count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} ufl_fifo_st_type;

	ufl_fifo_st_type q_r;
	ufl_fifo_st_type q_nxt;
	logic            do_in;
	logic            do_out;

	assign in_ready  = q_r.cnt != CW'(DEPTH);
	assign out_valid = q_r.cnt != '0;
	assign out_data  = q_r.mem[q_r.rp];
	assign count     = q_r.cnt;
	assign do_in     = in_valid && in_ready;
	assign do_out    = out_valid && out_ready;

	// Pointer update; flush wins over a same-cycle push or pop
	always_comb begin
		q_nxt = q_r;
		if (do_in) begin
			q_nxt.mem[q_r.wp] = in_data;
			q_nxt.wp = q_r.wp + AW'(1);
		end
		if (do_out) begin
			q_nxt.rp = q_r.rp + AW'(1);
		end
		q_nxt.cnt = q_r.cnt + CW'(do_in) - CW'(do_out);
		if (flush) begin
			q_nxt.wp  = '0;
			q_nxt.rp  = '0;
			q_nxt.cnt = '0;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end
endmodule : ufl_fifo

// Overview of operation
// - Status bit 0 reads low while anything is pending, high when idle.
// - Receive pending once the receive count reaches the 1/4/8/14 trigger.
// - Transmit pending when count drops below trigger, or when fifo empties.
// - One trigger selection, latest written, serves both directions.
// - Dma mode bit is stored and does nothing else.
// - Transmit reset bit clears transmit fifo only; shifter untouched; self-clears.
// - Receive reset bit clears receive fifo only; shifter untouched; self-clears.
// - Fifo control writes with enable low ignore every other field.
// - Latch access bit steers offsets to the divisor latches.
// - Break bit holds the serial output low until cleared.
// - Parity enable adds a parity bit on transmit and checks it on receive.
// - Parity type zero means odd, one means even.
// - Forced parity sends and expects the inverse of the parity type bit.
// - Stop select gives 1, or 1.5 for 5-bit, else 2 stop bits.
// - Word length field selects 5, 6, 7 or 8 data bits.
// - Status bits 7:6 read as ones with fifos enabled, zeros otherwise.
module ufl_top (
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	input  wire ufl_pkg::ufl_bus_type bus,
	output logic [7:0]               rd_data,
	input  wire logic                rx_pin,
	output logic                     tx_pin
);
	import ufl_pkg::*;

	typedef struct packed {
		ufl_lcr_type line_format_control;
		logic        fen;
		logic        dma;
		logic [1:0]  tsel;
		logic [7:0]  dll;
		logic [7:0]  divisor_high_latch;
		logic [7:0]  divisor_fraction_latch;
		logic        tx_pend;
		logic        tx_armed;
		logic        tx_was_empty;
		logic        ovr;
		logic        perr;
		logic        ferr;
		logic [7:0]  rdata;
		logic        rx_s1;
		logic        rx_s2;
		logic [15:0] bcnt;
		ufl_ser_type tst;
		logic [5:0]  tcnt;
		logic [2:0]  tbit;
		logic [7:0]  tsh;
		logic        tpar;
		logic        txo;
		ufl_ser_type rst;
		logic [5:0]  rcnt;
		logic [2:0]  rbit;
		logic [7:0]  rsh;
		logic        rpe;
	} ufl_top_st_type;

	ufl_top_st_type q_r;
	ufl_top_st_type q_nxt;
	logic [4:0]     lvl;
	logic [4:0]     tx_cnt;
	logic [4:0]     rx_cnt;
	logic           rx_hit;
	logic           tick;
	logic [15:0]    divisor;
	logic [2:0]     nb_last;
	logic [7:0]     wmask;
	logic [5:0]     stop_len;
	logic [7:0]     interrupt_status_reg;
	logic [7:0]     rx_word;
	logic           tx_wr;
	logic           tx_pop;
	logic           tx_flush;
	logic           tx_in_ready;
	logic           tx_out_valid;
	logic [7:0]     tx_out_data;
	logic           rx_push;
	logic           rx_acc;
	logic           rx_pop;
	logic           rx_flush;
	logic           rx_in_ready;
	logic           rx_out_valid;
	logic [7:0]     rx_out_data;
	logic           clr_tx;
	logic           clr_err;
	logic           evt_below;
	logic           evt_empty;

	// Parity bit for a masked character under the current format
	function automatic logic par_bit(input logic [7:0] d, input ufl_lcr_type l);
		if (l.force_par) begin
			return ~l.even;
		end
		return l.even ? ^d : ~^d;
	endfunction : par_bit

	// Without fifos both queues behave as single holding registers
	assign lvl      = q_r.fen ? ufl_trig(q_r.tsel) : 5'h01;
	assign rx_hit   = rx_cnt >= lvl;
	assign divisor  = {q_r.divisor_high_latch, q_r.dll};
	assign tick     = q_r.bcnt == 16'h0000;
	assign nb_last  = 3'({1'b0, q_r.line_format_control.wl} + 3'h4);
	assign wmask    = 8'(8'hFF >> (2'h3 - q_r.line_format_control.wl));
	assign rx_word  = 8'(q_r.rsh >> (3'h7 - nb_last));
	assign rx_acc   = rx_in_ready && (q_r.fen || rx_cnt == 5'h00);
	assign stop_len = !q_r.line_format_control.stop2 ? OVS : (q_r.line_format_control.wl == 2'h0 ? STOP15 : STOP2);
	assign interrupt_status_reg      = {q_r.fen, q_r.fen, 2'h0,
		rx_hit ? ISR_RX : (q_r.tx_pend ? ISR_TX : ISR_NONE)};
	assign rd_data  = q_r.rdata;
	assign tx_pin   = q_r.txo;

	ufl_fifo #(.W(FIFO_W), .DEPTH(FIFO_D)) u_txq (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.flush     (tx_flush),
		.in_valid  (tx_wr && (q_r.fen || tx_cnt == 5'h00)),
		.in_ready  (tx_in_ready),
		.in_data   (bus.wdata),
		.out_valid (tx_out_valid),
		.out_ready (tx_pop),
		.out_data  (tx_out_data),
		.count     (tx_cnt)
	);

	ufl_fifo #(.W(FIFO_W), .DEPTH(FIFO_D)) u_rxq (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.flush     (rx_flush),
		.in_valid  (rx_push && rx_acc),
		.in_ready  (rx_in_ready),
		.in_data   (rx_word),
		.out_valid (rx_out_valid),
		.out_ready (rx_pop),
		.out_data  (rx_out_data),
		.count     (rx_cnt)
	);

	// Register access, serial engines and pending flags
	always_comb begin
		q_nxt    = q_r;
		tx_wr    = 1'b0;
		tx_pop   = 1'b0;
		tx_flush = 1'b0;
		rx_push  = 1'b0;
		rx_pop   = 1'b0;
		rx_flush = 1'b0;
		clr_tx   = 1'b0;
		clr_err  = 1'b0;
		q_nxt.rdata = 8'h00;
		// Host writes
		if (bus.wr) begin
			case (bus.addr)
				ADDR_DATA: begin
					if (q_r.line_format_control.dlab) begin
						q_nxt.dll = bus.wdata;
					end else begin
						tx_wr  = 1'b1;
						clr_tx = 1'b1;
					end
				end
				ADDR_DIVH: begin
					if (q_r.line_format_control.dlab) begin
						q_nxt.divisor_high_latch = bus.wdata;
					end
				end
				ADDR_ISR: begin
					q_nxt.fen = bus.wdata[FCR_EN];
					if (bus.wdata[FCR_EN]) begin
						q_nxt.dma = bus.wdata[FCR_DMA];
						// A changed receive field is the newer choice
						q_nxt.tsel = (bus.wdata[FCR_RTRIG+:2] != q_r.tsel) ?
							bus.wdata[FCR_RTRIG+:2] : bus.wdata[FCR_TTRIG+:2];
						tx_flush = bus.wdata[FCR_TXRST];
						rx_flush = bus.wdata[FCR_RXRST];
					end
					if (bus.wdata[FCR_EN] != q_r.fen) begin
						tx_flush = 1'b1;
						rx_flush = 1'b1;
					end
				end
				ADDR_LCR: begin
					q_nxt.line_format_control = ufl_lcr_type'(bus.wdata);
				end
				ADDR_DIVF: begin
					if (q_r.line_format_control.dlab) begin
						q_nxt.divisor_fraction_latch = bus.wdata;
					end
				end
				default: begin
				end
			endcase
		end
		// Host reads; data stands for one cycle only
		if (bus.rd) begin
			case (bus.addr)
				ADDR_DATA: begin
					if (q_r.line_format_control.dlab) begin
						q_nxt.rdata = q_r.dll;
					end else begin
						q_nxt.rdata = rx_out_valid ? rx_out_data : 8'h00;
						rx_pop = rx_out_valid;
					end
				end
				ADDR_DIVH: q_nxt.rdata = q_r.line_format_control.dlab ? q_r.divisor_high_latch : 8'h00;
				ADDR_ISR: begin
					q_nxt.rdata = interrupt_status_reg;
					clr_tx = 1'b1;
				end
				ADDR_LCR: q_nxt.rdata = q_r.line_format_control;
				ADDR_DIVF: q_nxt.rdata = q_r.line_format_control.dlab ? q_r.divisor_fraction_latch : 8'h00;
				ADDR_STAT: begin
					q_nxt.rdata = {1'b0, !tx_in_ready, !tx_out_valid, 1'b0,
						q_r.ferr, q_r.perr, q_r.ovr, rx_out_valid};
					clr_err = 1'b1;
				end
				default: q_nxt.rdata = 8'h00;
			endcase
		end
		if (clr_err) begin
			q_nxt.ovr  = 1'b0;
			q_nxt.perr = 1'b0;
			q_nxt.ferr = 1'b0;
		end
		// Baud tick; fraction latch is stored but not used by the divider
		q_nxt.bcnt = tick ? ((divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001)
			: q_r.bcnt - 16'h0001;
		// Two-stage synchroniser for the line input
		q_nxt.rx_s1 = rx_pin;
		q_nxt.rx_s2 = q_r.rx_s1;
		// Transmit engine
		if (tick) begin
			q_nxt.tcnt = q_r.tcnt + 6'h01;
			case (q_r.tst)
				SER_IDLE: begin
					if (tx_out_valid) begin
						tx_pop      = 1'b1;
						q_nxt.tsh   = tx_out_data & wmask;
						q_nxt.tpar  = par_bit(tx_out_data & wmask, q_r.line_format_control);
						q_nxt.tst   = SER_START;
						q_nxt.tcnt  = 6'h00;
					end
				end
				SER_START: begin
					if (q_r.tcnt == OVS - 6'h01) begin
						q_nxt.tst  = SER_DATA;
						q_nxt.tcnt = 6'h00;
						q_nxt.tbit = 3'h0;
					end
				end
				SER_DATA: begin
					if (q_r.tcnt == OVS - 6'h01) begin
						q_nxt.tcnt = 6'h00;
						q_nxt.tsh  = q_r.tsh >> 1;
						q_nxt.tbit = q_r.tbit + 3'h1;
						if (q_r.tbit == nb_last) begin
							q_nxt.tst = q_r.line_format_control.pen ? SER_PAR : SER_STOP;
						end
					end
				end
				SER_PAR: begin
					if (q_r.tcnt == OVS - 6'h01) begin
						q_nxt.tst  = SER_STOP;
						q_nxt.tcnt = 6'h00;
					end
				end
				SER_STOP: begin
					if (q_r.tcnt == stop_len - 6'h01) begin
						q_nxt.tst = SER_IDLE;
					end
				end
				default: q_nxt.tst = SER_IDLE;
			endcase
		end
		// Line level follows the next state, so break acts at once
		case (q_nxt.tst)
			SER_START: q_nxt.txo = 1'b0;
			SER_DATA: q_nxt.txo = q_nxt.tsh[0];
			SER_PAR: q_nxt.txo = q_nxt.tpar;
			default: q_nxt.txo = 1'b1;
		endcase
		if (q_nxt.line_format_control.brk) begin
			q_nxt.txo = 1'b0;
		end
		// Receive engine samples mid-bit at 16x
		if (tick) begin
			q_nxt.rcnt = q_r.rcnt + 6'h01;
			case (q_r.rst)
				SER_IDLE: begin
					if (!q_r.rx_s2) begin
						q_nxt.rst  = SER_START;
						q_nxt.rcnt = 6'h00;
					end
				end
				SER_START: begin
					if (q_r.rcnt == HALF - 6'h01) begin
						// A short low pulse is a glitch, not a start bit
						q_nxt.rst  = q_r.rx_s2 ? SER_IDLE : SER_DATA;
						q_nxt.rcnt = 6'h00;
						q_nxt.rbit = 3'h0;
						q_nxt.rpe  = 1'b0;
					end
				end
				SER_DATA: begin
					if (q_r.rcnt == OVS - 6'h01) begin
						q_nxt.rcnt = 6'h00;
						q_nxt.rsh  = {q_r.rx_s2, q_r.rsh[7:1]};
						q_nxt.rbit = q_r.rbit + 3'h1;
						if (q_r.rbit == nb_last) begin
							q_nxt.rst = q_r.line_format_control.pen ? SER_PAR : SER_STOP;
						end
					end
				end
				SER_PAR: begin
					if (q_r.rcnt == OVS - 6'h01) begin
						q_nxt.rpe  = q_r.rx_s2 != par_bit(rx_word, q_r.line_format_control);
						q_nxt.rst  = SER_STOP;
						q_nxt.rcnt = 6'h00;
					end
				end
				SER_STOP: begin
					// Receiver checks the first stop bit only
					if (q_r.rcnt == OVS - 6'h01) begin
						rx_push   = 1'b1;
						q_nxt.rst = SER_IDLE;
						if (!q_r.rx_s2) begin
							q_nxt.ferr = 1'b1;
						end
						if (q_r.line_format_control.pen && q_r.rpe) begin
							q_nxt.perr = 1'b1;
						end
						if (!rx_acc) begin
							q_nxt.ovr = 1'b1;
						end
					end
				end
				default: q_nxt.rst = SER_IDLE;
			endcase
		end
		// Transmit pending: below trigger after a fill, or on emptying
		evt_below = q_r.tx_armed && tx_cnt < lvl;
		evt_empty = tx_cnt == 5'h00 && !q_r.tx_was_empty;
		q_nxt.tx_was_empty = tx_cnt == 5'h00;
		if (tx_cnt >= lvl) begin
			q_nxt.tx_armed = 1'b1;
		end else if (evt_below) begin
			q_nxt.tx_armed = 1'b0;
		end
		if (clr_tx) begin
			q_nxt.tx_pend = 1'b0;
		end
		if (evt_below || evt_empty) begin
			q_nxt.tx_pend = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			q_r              <= '0;
			q_r.line_format_control          <= ufl_lcr_type'(LCR_RST);
			q_r.dll          <= DIVL_RST;
			q_r.divisor_high_latch          <= DIVH_RST;
			q_r.divisor_fraction_latch          <= DIVF_RST;
			q_r.tx_was_empty <= 1'b1;
			q_r.rx_s1        <= 1'b1;
			q_r.rx_s2        <= 1'b1;
			q_r.txo          <= 1'b1;
		end else begin
			q_r <= q_nxt;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	isr_idle_a: assert property (
		bus.rd && bus.addr == ADDR_ISR |=> rd_data[0] == !($past(rx_hit) || $past(q_r.tx_pend)))
		else $error("pending bit wrong");
	rx_trig_a: assert property (
		bus.rd && bus.addr == ADDR_ISR && q_r.fen && q_r.tsel == 2'h3 && rx_cnt == 5'h0D
		|=> rd_data[3:0] != ISR_RX) else $error("receive trigger at 13 of 14");
	tx_empty_a: assert property (
		tx_cnt == 5'h00 && !q_r.tx_was_empty |=> q_r.tx_pend) else $error("no empty event");
	trig_common_a: assert property (
		bus.wr && bus.addr == ADDR_ISR && bus.wdata[0] && bus.wdata[7:6] != q_r.tsel
		|=> q_r.tsel == $past(bus.wdata[7:6])) else $error("trigger select lost");
	dma_keep_a: assert property (
		bus.wr && bus.addr == ADDR_ISR && bus.wdata[0] |=> q_r.dma == $past(bus.wdata[3]))
		else $error("dma bit not stored");
	tx_reset_a: assert property (
		bus.wr && bus.addr == ADDR_ISR && bus.wdata[0] && bus.wdata[2] |=> tx_cnt == 5'h00)
		else $error("transmit fifo not cleared");
	rx_reset_a: assert property (
		bus.wr && bus.addr == ADDR_ISR && bus.wdata[0] && bus.wdata[1] |=> rx_cnt == 5'h00)
		else $error("receive fifo not cleared");
	fen_ignore_a: assert property (
		bus.wr && bus.addr == ADDR_ISR && !bus.wdata[0]
		|=> $stable(q_r.tsel) && $stable(q_r.dma) && !q_r.fen) else $error("field taken");
	latch_write_a: assert property (
		bus.wr && bus.addr == ADDR_DATA && q_r.line_format_control.dlab |=> q_r.dll == $past(bus.wdata))
		else $error("divisor low not written");
	break_hold_a: assert property (
		q_r.line_format_control.brk |-> !tx_pin) else $error("break not held");
	fifo_bits_a: assert property (
		bus.rd && bus.addr == ADDR_ISR |=> rd_data[7:6] == {2{$past(q_r.fen)}})
		else $error("enable status bits wrong");
	mode_flush_a: assert property (
		bus.wr && bus.addr == ADDR_ISR && bus.wdata[0] != q_r.fen
		|=> tx_cnt == 5'h00 && rx_cnt == 5'h00) else $error("fifos kept on mode change");

	rx_char_c: cover property (rx_push && q_r.fen);
	tx_pend_c: cover property ($rose(q_r.tx_pend));
	parity_c: cover property (q_r.tst == SER_PAR);
	break_c: cover property (q_r.line_format_control.brk && q_r.tst == SER_DATA);
endmodule : ufl_top

// file: hw/ufl_pkg.sv
// Register map, field positions, reset values and types of the line format block.
// Assumes one 100 MHz clock and a byte-wide register port.
package ufl_pkg;
	// Register offsets
	localparam logic [2:0] ADDR_DATA = 3'h0; // Data, or divisor low with latch access
	localparam logic [2:0] ADDR_DIVH = 3'h1;
	localparam logic [2:0] ADDR_ISR  = 3'h2; // Read: status, write: fifo control
	localparam logic [2:0] ADDR_LCR  = 3'h3;
	localparam logic [2:0] ADDR_DIVF = 3'h4;
	localparam logic [2:0] ADDR_STAT = 3'h5;
	// Fifo control fields
	localparam int FCR_EN    = 0;
	localparam int FCR_RXRST = 1;
	localparam int FCR_TXRST = 2;
	localparam int FCR_DMA   = 3;
	localparam int FCR_TTRIG = 4;
	localparam int FCR_RTRIG = 6;
	// Reset values
	localparam logic [7:0] LCR_RST  = 8'h00;
	localparam logic [7:0] DIVL_RST = 8'h01;
	localparam logic [7:0] DIVH_RST = 8'h00;
	localparam logic [7:0] DIVF_RST = 8'h00;
	// Status codes in the low nibble
	localparam logic [3:0] ISR_NONE = 4'h1;
	localparam logic [3:0] ISR_RX   = 4'h4;
	localparam logic [3:0] ISR_TX   = 4'h2;
	// Fifo shape
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 16;
	// Oversampling ticks per bit and per stop length
	localparam logic [5:0] OVS    = 6'h10;
	localparam logic [5:0] HALF   = 6'h08;
	localparam logic [5:0] STOP15 = 6'h18;
	localparam logic [5:0] STOP2  = 6'h20;

	typedef struct packed {
		logic       dlab;
		logic       brk;
		logic       force_par;
		logic       even;
		logic       pen;
		logic       stop2;
		logic [1:0] wl;
	} ufl_lcr_type;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} ufl_bus_type;

	typedef enum logic [2:0] {SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP} ufl_ser_type;

	// Shared trigger table
	function automatic logic [4:0] ufl_trig(input logic [1:0] sel);
		case (sel)
			2'h0: return 5'h01;
			2'h1: return 5'h04;
			2'h2: return 5'h08;
			default: return 5'h0E;
		endcase
	endfunction : ufl_trig
endpackage : ufl_pkg

// file: verif/ufl_remote.sv
// Remote serial device: drives the receive line and watches the send line.
// Assumes divisor 1, so one bit lasts 16 clk_sys cycles.
`timescale 1ns/1ps
module ufl_remote (
	input  wire logic clk_sys,
	input  wire logic tx_pin,
	output logic      rx_pin
);
	int cyc = 0;

	// Mark is the idle level of the line
	initial rx_pin = 1'b1;

	// Free count, used to time the distance between start bits
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
	end

	// Sends n bits LSB first, then idles at mark
	task automatic send(input logic [11:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			rx_pin <= f[i];
			repeat (16) @(posedge clk_sys);
		end
		rx_pin <= 1'b1;
		repeat (16) @(posedge clk_sys);
	endtask : send

	// Catches one frame at mid bit; t is the start cycle, -1 if none came
	task automatic grab(output logic [11:0] f, output int t, input int n);
		int k;
		f = '0;
		for (k = 0; k < 4000 && tx_pin !== 1'b0; k++) @(posedge clk_sys);
		t = (k < 4000) ? cyc : -1;
		repeat (8) @(posedge clk_sys);
		for (int i = 0; i < n; i++) begin
			f[i] = tx_pin;
			// No wait after the stop sample, a next start may follow at once
			if (i < n - 1) repeat (16) @(posedge clk_sys);
		end
	endtask : grab
endmodule : ufl_remote

// file: verif/ufl_top_tb_top.sv
// Self-checking bench of the line format block with a remote serial device.
// Assumes divisor 1 after reset, so a serial bit lasts 16 cycles.
`timescale 1ns/1ps
module ufl_top_tb_top;
	import ufl_pkg::*;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        rx_pin;
	logic        tx_pin;
	logic [7:0]  rd_data;
	ufl_bus_type bus = '0;
	int          mismatches = 0;
	int          cmp_count = 0;
	logic [7:0]  rv, d0, d1, l;
	logic [7:0]  fc [6];
	int          tg [6];
	logic [11:0] f0, f1, e0, e1;
	int          t0, t1, n, z;

	always #5 clk_sys = ~clk_sys;

	ufl_top ufl_top_i (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.bus    (bus),
		.rd_data(rd_data),
		.rx_pin (rx_pin),
		.tx_pin (tx_pin)
	);

	ufl_remote ufl_remote_i (
		.clk_sys(clk_sys),
		.tx_pin (tx_pin),
		.rx_pin (rx_pin)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results

	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
	endtask : tick

	// One gap cycle after each access keeps strobes from being set twice
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge clk_sys);
		bus <= '0;
		@(posedge clk_sys);
	endtask : wr

	// Read data stand in the cycle after the strobe only
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		bus <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_sys);
		bus <= '0;
		@(posedge clk_sys);
		d = rd_data;
	endtask : rd

	// Expected frame LSB first: start, data, parity, first stop
	function automatic logic [11:0] frm(input logic [7:0] d, input logic [7:0] c, output int n);
		logic [11:0] f;
		int          w;
		f = '0;
		w = 5 + int'(c[1:0]);
		for (int i = 0; i < w; i++) f[i+1] = d[i];
		n = w + 1;
		if (c[3]) begin
			f[n] = c[5] ? ~c[4] : (~^f) ^ c[4];
			n++;
		end
		f[n] = 1'b1;
		n++;
		return f;
	endfunction : frm

	// Stuck waits still end with a verdict
	initial begin
		#1000000;
		mismatches++;
		results();
	end

	initial begin
		fc = '{8'h07, 8'h4F, 8'h87, 8'hC7, 8'hD7, 8'h87}; // on the second row
		tg = '{1, 4, 8, 14, 4, 8};
		void'($urandom(32'hEE53));
		tick(12);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		// Reset values, divisor steering, unmapped place
		rd(ADDR_ISR, rv);
		chk(rv, 8'h01);
		rd(ADDR_LCR, rv);
		chk(rv, LCR_RST);
		wr(ADDR_LCR, 8'h80);
		rd(ADDR_DATA, rv);
		chk(rv, DIVL_RST);
		// Small divisor only, so the baud counter reloads within a few cycles
		wr(ADDR_DATA, 8'h03);
		rd(ADDR_DATA, rv);
		chk(rv, 8'h03);
		wr(ADDR_DATA, DIVL_RST);
		rd(ADDR_STAT, rv);
		chk(rv[5], 1'b1);
		wr(ADDR_DIVF, 8'h5A);
		rd(ADDR_DIVF, rv);
		chk(rv, 8'h5A);
		wr(ADDR_LCR, 8'h00);
		rd(ADDR_DIVF, rv);
		chk(rv, 8'h00);
		rd(3'h6, rv);
		chk(rv, 8'h00);
		$display("test reset done");
		// Every format, two chars back to back to see the stop length
		wr(ADDR_ISR, 8'h01);
		for (int m = 0; m < 64; m++) begin
			tick(40);
			l = 8'(m);
			wr(ADDR_LCR, l);
			rd(ADDR_LCR, rv);
			chk(rv, l);
			d0 = 8'($urandom);
			d1 = 8'($urandom);
			e0 = frm(d0, l, n);
			e1 = frm(d1, l, n);
			fork
				begin
					ufl_remote_i.grab(f0, t0, n);
					ufl_remote_i.grab(f1, t1, n);
				end
				begin
					wr(ADDR_DATA, d0);
					wr(ADDR_DATA, d1);
				end
			join
			z = !l[2] ? 16 : (l[1:0] == 2'b00) ? 24 : 32;
			chk(f0, e0);
			chk(f1, e1);
			// One idle tick follows each stop before the next start
			chk(t1 - t0, 16 * (n - 1) + z + 1);
			if (t0 < 0 || t1 < 0) results();
		end
		$display("test tx format done");
		// Trigger rows; stale chars left from the last row must be flushed
		wr(ADDR_LCR, 8'h03);
		for (int r = 0; r < 6; r++) begin
			if (r == 5) begin
				wr(ADDR_ISR, 8'h00);
				wr(ADDR_ISR, 8'h86);
				rd(ADDR_ISR, rv);
				chk(rv[7:6], 2'b00);
				rd(ADDR_STAT, rv);
				chk(rv[0], 1'b0);
			end
			wr(ADDR_ISR, fc[r]);
			rd(ADDR_STAT, rv);
			chk(rv[0], 1'b0);
			for (int k = 0; k < tg[r]; k++) begin
				rd(ADDR_ISR, rv);
				chk(rv[3:0] == ISR_RX, 1'b0);
				chk(rv[7:6], 2'b11);
				d1 = 8'($urandom);
				if (k == 0) d0 = d1;
				e0 = frm(d1, 8'h03, n);
				ufl_remote_i.send(e0, n);
			end
			rd(ADDR_ISR, rv);
			chk(rv, {2'b11, 2'b00, ISR_RX});
			rd(ADDR_DATA, rv);
			chk(rv, d0);
		end
		$display("test rx trigger done");
		// Parity and framing faults from the remote side
		wr(ADDR_LCR, 8'h0B);
		rd(ADDR_STAT, rv);
		e0 = frm(8'($urandom), 8'h0B, n);
		ufl_remote_i.send(e0, n);
		rd(ADDR_STAT, rv);
		chk(rv[3:2], 2'b00);
		ufl_remote_i.send(e0 ^ 12'h200, n);
		rd(ADDR_STAT, rv);
		chk(rv[3:2], 2'b01);
		ufl_remote_i.send(e0 ^ 12'h400, n);
		rd(ADDR_STAT, rv);
		chk(rv[3:2], 2'b10);
		$display("test rx errors done");
		// Transmit pending below trigger 4, then again on empty
		wr(ADDR_LCR, 8'h03);
		wr(ADDR_ISR, 8'h47);
		repeat (6) wr(ADDR_DATA, 8'($urandom));
		rd(ADDR_ISR, rv);
		chk(rv, 8'hC1);
		tick(400);
		rd(ADDR_ISR, rv);
		chk(rv, 8'hC2);
		rd(ADDR_ISR, rv);
		chk(rv, 8'hC1);
		tick(600);
		rd(ADDR_ISR, rv);
		chk(rv, 8'hC2);
		$display("test tx pending done");
		// Transmit flush mid-char: shifter finishes, queued chars vanish
		d0 = 8'($urandom);
		e0 = frm(d0, 8'h03, n);
		fork
			ufl_remote_i.grab(f0, t0, n);
			begin
				wr(ADDR_DATA, d0);
				wr(ADDR_DATA, 8'($urandom));
				wr(ADDR_DATA, 8'($urandom));
				wr(ADDR_ISR, 8'h45);
				rd(ADDR_STAT, rv);
				chk(rv[5], 1'b1);
			end
		join
		chk(f0, e0);
		ufl_remote_i.grab(f1, t1, n);
		chk(t1, -1);
		$display("test tx flush done");
		// Break holds the line at space until cleared
		wr(ADDR_LCR, 8'h43);
		z = 0;
		repeat (40) begin
			@(posedge clk_sys);
			z += int'(tx_pin !== 1'b0);
		end
		chk(z, 0);
		wr(ADDR_LCR, 8'h03);
		tick(2);
		chk(tx_pin, 1'b1);
		$display("test break done");
		results();
	end
endmodule : ufl_top_tb_top
